//--- iesae_pkg.sv
// iesae_pkg: register indices, field positions, reset values and write masks
// for the interrupt edge-select and enable block.
// assumes: 8-bit registers, each in one aligned 32-bit word of the APB space.
package iesae_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_EXT_EDGE = 6'h02;
    localparam logic [5:0] IDX_PIN_EDGE = 6'h03;
    localparam logic [5:0] IDX_TMR_EN = 6'h04;
    localparam logic [5:0] IDX_PER_EN = 6'h05;
    localparam logic [5:0] IDX_FLAG1 = 6'h07;
    localparam logic [5:0] IDX_FLAG2 = 6'h08;
    localparam logic [5:0] IDX_FLAG3 = 6'h09;
    localparam logic [1:0] ADDR_ALIGN = 2'h0;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // reset values and write masks (reserved bits are outside the mask)
    // ------------------------------------------------------------
    localparam logic [7:0] EXT_EDGE_RST = 8'h70;
    localparam logic [7:0] EXT_EDGE_WMASK = 8'h0F;
    localparam logic [7:0] PIN_EDGE_RST = 8'h00;
    localparam logic [7:0] PIN_EDGE_WMASK = 8'hFF;
    localparam logic [7:0] TMR_EN_RST = 8'h10;
    localparam logic [7:0] TMR_EN_WMASK = 8'hCF;
    localparam logic [7:0] PER_EN_RST = 8'h00;
    localparam logic [7:0] PER_EN_WMASK = 8'hD0;
    localparam logic [7:0] FLAG1_RST = 8'h10;
    localparam logic [7:0] FLAG1_CMASK = 8'hCF;
    localparam logic [7:0] FLAG2_RST = 8'h00;
    localparam logic [7:0] FLAG2_CMASK = 8'hD0;
    localparam logic [7:0] FLAG3_RST = 8'h00;
    localparam logic [7:0] FLAG3_CMASK = 8'hFF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_TIMER_B_ONE = 7;
    localparam int BIT_TIMER_A = 6;
    localparam int BIT_DIRECT_TRANSFER = 7;
    localparam int BIT_CONVERTER_DONE = 6;
    localparam int BIT_SERIAL_ONE_DONE = 4;
    localparam int BIT_PIN7 = 7;
    localparam int BIT_PIN6 = 6;
    localparam int BIT_PIN5 = 5;
    localparam int EXT_PINS = 4;
    localparam int NUM_PINS = 8;
    localparam int ALL_PINS = 15;

    // pin synchroniser reset level: pins idle high, so no false falling edge
    localparam logic PIN_IDLE = 1'b1;

endpackage : iesae_pkg

//--- iesae_edge_detect.sv
// iesae_edge_detect: one pin synchroniser with selectable edge detection.
// assumes: pin is asynchronous to pclk; rising_sel is a register output.
`timescale 1ns/100ps
module iesae_edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    input wire logic rising_sel,
    output logic edge_pulse
);
    import iesae_pkg::*;

    // ------------------------------------------------------------
    // synchroniser and history
    // ------------------------------------------------------------
    logic sync_meta;
    logic sync_pin;
    logic prev_pin;

    // the first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta <= PIN_IDLE;
            sync_pin <= PIN_IDLE;
            prev_pin <= PIN_IDLE;
        end else begin
            sync_meta <= pin;
            sync_pin <= sync_meta;
            prev_pin <= sync_pin;
        end
    end

    // one-cycle pulse on the chosen edge: 0 falling, 1 rising
    assign edge_pulse = rising_sel ? (sync_pin & ~prev_pin) : (~sync_pin & prev_pin);

endmodule // iesae_edge_detect

//--- iesae_top.sv
// iesae_top: interrupt edge-select and enable registers with request flags.
// assumes: APB master in the pclk domain; peripheral events are one-cycle
// pulses synchronous to pclk; cpu_int_mask is the CPU global mask level.
//
// Function
// - first edge-select register resets to 0x70; reserved bits fixed, writes ignored.
// - first edge-select bit 7 reads zero and never changes.
// - bit 3 selects falling (0) or rising (1) edge for request pin three.
// - bits 2..0 select falling or rising edge for request pins two..zero.
// - second edge-select register fully writable, resets to 0x00.
// - bit 7 sets edge for numbered pin seven and timer Y input.
// - bit 6 sets edge for numbered pin six and timer B input.
// - bit 5 sets edge for numbered pin five and converter trigger.
// - bits 4..0 select edge for numbered pins four..zero.
// - first enable register resets 0x10; bit 5 reads 0, bit 4 reads 1.
// - first enable bit 7 gates timer B1 overflow requests, default blocked.
// - first enable bit 6 gates timer A overflow requests, default blocked.
// - first enable bits 3..0 gate request pins three..zero, default blocked.
// - second enable register resets 0x00; bits 5 and 3..0 read zero.
// - second enable bit 7 gates direct-transfer requests.
// - second enable bit 6 gates converter-done requests.
// - second enable bit 4 gates serial channel one done requests.
// - flags set by events, never auto-clear; writing 0 clears, 1 no effect.
// - with global mask set, flags still set but nothing is accepted.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module iesae_top (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [iesae_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request pins and shared-edge pins
    input wire logic [3:0] ext_request_pin,
    input wire logic [7:0] numbered_irq_pin,
    input wire logic timer_y_event_in,
    input wire logic timer_b_event_in,
    input wire logic converter_trigger_in,
    // detected edges of the shared-edge pins, for the timers and converter
    output logic timer_y_edge,
    output logic timer_b_edge,
    output logic converter_trigger_edge,
    // peripheral events, one-cycle pulses
    input wire logic timer_b_one_overflow,
    input wire logic timer_a_overflow,
    input wire logic direct_transfer_event,
    input wire logic converter_done_event,
    input wire logic serial_one_done_event,
    // cpu side
    input wire logic cpu_int_mask,
    output logic [3:0] ext_req_request,
    output logic [7:0] numbered_pin_request,
    output logic timer_b_one_request,
    output logic timer_a_request,
    output logic direct_transfer_request,
    output logic converter_done_request,
    output logic serial_one_done_request,
    output logic irq_accept
);
    import iesae_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ext_request_edge_select;
    logic [7:0] numbered_pin_edge_select;
    logic [7:0] timer_and_ext_request_enable;
    logic [7:0] peripheral_request_enable;
    logic [7:0] request_flags1;
    logic [7:0] request_flags2;
    logic [7:0] request_flags3;
    logic [7:0] next_ext_request_edge_select;
    logic [7:0] next_numbered_pin_edge_select;
    logic [7:0] next_timer_and_ext_request_enable;
    logic [7:0] next_peripheral_request_enable;
    logic [7:0] next_request_flags1;
    logic [7:0] next_request_flags2;
    logic [7:0] next_request_flags3;
    logic [31:0] next_prdata;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire [5:0] word_idx = paddr[ADDR_W-1:2];
    wire aligned = (paddr[1:0] == ADDR_ALIGN);
    wire hit_ext_edge = aligned && (word_idx == IDX_EXT_EDGE);
    wire hit_pin_edge = aligned && (word_idx == IDX_PIN_EDGE);
    wire hit_tmr_en = aligned && (word_idx == IDX_TMR_EN);
    wire hit_per_en = aligned && (word_idx == IDX_PER_EN);
    wire hit_flag1 = aligned && (word_idx == IDX_FLAG1);
    wire hit_flag2 = aligned && (word_idx == IDX_FLAG2);
    wire hit_flag3 = aligned && (word_idx == IDX_FLAG3);
    wire hit_any = hit_ext_edge | hit_pin_edge | hit_tmr_en | hit_per_en |
                   hit_flag1 | hit_flag2 | hit_flag3;

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // a write lands only at the completing access edge, and only if mapped
    wire wr_en = psel & penable & pwrite & pready;
    wire setup_rd = psel & ~penable & ~pwrite;
    wire [7:0] wbyte = pwdata[7:0];

    // ------------------------------------------------------------
    // pin edge detection
    // ------------------------------------------------------------
    // all fifteen pins use one detector instance each; the three shared pins
    // reuse the edge bits of numbered pins seven, six and five
    wire [ALL_PINS-1:0] pin_vec = {converter_trigger_in, timer_b_event_in,
                                   timer_y_event_in, numbered_irq_pin,
                                   ext_request_pin};
    wire [ALL_PINS-1:0] sel_vec = {numbered_pin_edge_select[BIT_PIN5],
                                   numbered_pin_edge_select[BIT_PIN6],
                                   numbered_pin_edge_select[BIT_PIN7],
                                   numbered_pin_edge_select,
                                   ext_request_edge_select[EXT_PINS-1:0]};
    wire [ALL_PINS-1:0] edge_vec;

    // one synchroniser per pin ahead of the edge compare
    genvar gi;
    generate
        for (gi = 0; gi < ALL_PINS; gi++) begin : g_pin
            iesae_edge_detect u_det (
                .pclk(pclk),
                .presetn(presetn),
                .pin(pin_vec[gi]),
                .rising_sel(sel_vec[gi]),
                .edge_pulse(edge_vec[gi])
            );
        end
    endgenerate

    wire [3:0] ext_edge = edge_vec[EXT_PINS-1:0];
    wire [7:0] num_edge = edge_vec[EXT_PINS+NUM_PINS-1:EXT_PINS];
    assign timer_y_edge = edge_vec[EXT_PINS+NUM_PINS];
    assign timer_b_edge = edge_vec[EXT_PINS+NUM_PINS+1];
    assign converter_trigger_edge = edge_vec[EXT_PINS+NUM_PINS+2];

    // ------------------------------------------------------------
    // configuration register next values
    // ------------------------------------------------------------
    // masked writes keep reserved bits at their reset constants
    assign next_ext_request_edge_select = (wr_en && hit_ext_edge) ?
        ((ext_request_edge_select & ~EXT_EDGE_WMASK) | (wbyte & EXT_EDGE_WMASK)) :
        ext_request_edge_select;
    assign next_numbered_pin_edge_select = (wr_en && hit_pin_edge) ?
        (wbyte & PIN_EDGE_WMASK) : numbered_pin_edge_select;
    assign next_timer_and_ext_request_enable = (wr_en && hit_tmr_en) ?
        ((timer_and_ext_request_enable & ~TMR_EN_WMASK) | (wbyte & TMR_EN_WMASK)) :
        timer_and_ext_request_enable;
    assign next_peripheral_request_enable = (wr_en && hit_per_en) ?
        ((peripheral_request_enable & ~PER_EN_WMASK) | (wbyte & PER_EN_WMASK)) :
        peripheral_request_enable;

    // ------------------------------------------------------------
    // request flag next values
    // ------------------------------------------------------------
    // a zero written to a flag bit clears it; ones and reserved bits do nothing
    wire [7:0] clr1 = (wr_en && hit_flag1) ? (~wbyte & FLAG1_CMASK) : 8'h00;
    wire [7:0] clr2 = (wr_en && hit_flag2) ? (~wbyte & FLAG2_CMASK) : 8'h00;
    wire [7:0] clr3 = (wr_en && hit_flag3) ? (~wbyte & FLAG3_CMASK) : 8'h00;

    // set sources placed at their flag positions
    wire [7:0] set1 = ({timer_b_one_overflow, timer_a_overflow, 6'h00} |
                       {4'h0, ext_edge}) & FLAG1_CMASK;
    wire [7:0] set2 = {direct_transfer_event, converter_done_event, 1'b0,
                       serial_one_done_event, 4'h0} & FLAG2_CMASK;
    wire [7:0] set3 = num_edge & FLAG3_CMASK;

    // set wins over a clear in the same cycle so no event is lost; the
    // cpu mask never enters here, so flags keep setting while masked
    assign next_request_flags1 = (request_flags1 & ~clr1) | set1;
    assign next_request_flags2 = (request_flags2 & ~clr2) | set2;
    assign next_request_flags3 = (request_flags3 & ~clr3) | set3;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // read value captured in the setup cycle so prdata comes from a flop
    wire [7:0] rd_byte =
        hit_ext_edge ? ext_request_edge_select :
        hit_pin_edge ? numbered_pin_edge_select :
        hit_tmr_en ? timer_and_ext_request_enable :
        hit_per_en ? peripheral_request_enable :
        hit_flag1 ? request_flags1 :
        hit_flag2 ? request_flags2 :
        hit_flag3 ? request_flags3 : 8'h00;
    assign next_prdata = setup_rd ? {24'h000000, rd_byte} : prdata;

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_request_edge_select <= EXT_EDGE_RST;
            numbered_pin_edge_select <= PIN_EDGE_RST;
            timer_and_ext_request_enable <= TMR_EN_RST;
            peripheral_request_enable <= PER_EN_RST;
        end else begin
            ext_request_edge_select <= next_ext_request_edge_select;
            numbered_pin_edge_select <= next_numbered_pin_edge_select;
            timer_and_ext_request_enable <= next_timer_and_ext_request_enable;
            peripheral_request_enable <= next_peripheral_request_enable;
        end
    end

    // request flags and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_flags1 <= FLAG1_RST;
            request_flags2 <= FLAG2_RST;
            request_flags3 <= FLAG3_RST;
            prdata <= 32'h00000000;
        end else begin
            request_flags1 <= next_request_flags1;
            request_flags2 <= next_request_flags2;
            request_flags3 <= next_request_flags3;
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // requests toward the cpu
    // ------------------------------------------------------------
    // each request is the and of its flag and its enable
    assign timer_b_one_request = request_flags1[BIT_TIMER_B_ONE] &
        timer_and_ext_request_enable[BIT_TIMER_B_ONE];
    assign timer_a_request = request_flags1[BIT_TIMER_A] &
        timer_and_ext_request_enable[BIT_TIMER_A];
    assign ext_req_request = request_flags1[EXT_PINS-1:0] &
        timer_and_ext_request_enable[EXT_PINS-1:0];
    assign direct_transfer_request = request_flags2[BIT_DIRECT_TRANSFER] &
        peripheral_request_enable[BIT_DIRECT_TRANSFER];
    assign converter_done_request = request_flags2[BIT_CONVERTER_DONE] &
        peripheral_request_enable[BIT_CONVERTER_DONE];
    assign serial_one_done_request = request_flags2[BIT_SERIAL_ONE_DONE] &
        peripheral_request_enable[BIT_SERIAL_ONE_DONE];

    // the enables for the numbered pins live outside this block, so the
    // raw flags go out and the far side applies its own gate
    assign numbered_pin_request = request_flags3;

    // any pending request may be taken only while the global mask is clear
    wire any_request = timer_b_one_request | timer_a_request |
                       (|ext_req_request) | direct_transfer_request |
                       converter_done_request | serial_one_done_request |
                       (|numbered_pin_request);
    assign irq_accept = any_request & ~cpu_int_mask;

endmodule // iesae_top

//--- iesae_pkg_unused_guard.sv
// iesae_pkg_unused_guard: intentionally empty; holds no definitions.

//--- iesae_top_sva.sv
// iesae_top_sva: port-level checks for the interrupt edge-select and enable block.
// assumes: one pclk domain, presetn asynchronous and active low.
`timescale 1ns/100ps
module iesae_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic direct_transfer_event,
    input wire logic converter_done_event,
    input wire logic serial_one_done_event,
    input wire logic cpu_int_mask,
    input wire logic [3:0] ext_req_request,
    input wire logic [7:0] numbered_pin_request,
    input wire logic timer_b_one_request,
    input wire logic timer_a_request,
    input wire logic direct_transfer_request,
    input wire logic converter_done_request,
    input wire logic serial_one_done_request,
    input wire logic irq_accept,
    input wire logic timer_y_edge,
    input wire logic timer_b_edge,
    input wire logic converter_trigger_edge
);
    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    // only a completed bus write may clear a flag or an enable
    wire wr_acc = psel & penable & pwrite;
    wire any_req = (|ext_req_request) | (|numbered_pin_request) | timer_b_one_request
        | timer_a_request | direct_transfer_request | converter_done_request
        | serial_one_done_request;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    property p_accept; irq_accept == (any_req && !cpu_int_mask); endproperty
    a_accept: assert property (p_accept) else $error("accept does not follow mask");
    property p_tb1_hold; timer_b_one_request && !wr_acc |=> timer_b_one_request; endproperty
    a_tb1_hold: assert property (p_tb1_hold) else $error("timer b1 request lost");
    property p_ta_hold; timer_a_request && !wr_acc |=> timer_a_request; endproperty
    a_ta_hold: assert property (p_ta_hold) else $error("timer a request lost");
    property p_dt_rise;
        $rose(direct_transfer_request) |-> $past(direct_transfer_event) || $past(wr_acc);
    endproperty
    a_dt_rise: assert property (p_dt_rise) else $error("direct request without cause");
    property p_ad_rise;
        $rose(converter_done_request) |-> $past(converter_done_event) || $past(wr_acc);
    endproperty
    a_ad_rise: assert property (p_ad_rise) else $error("converter request without cause");
    property p_ser_stable;
        !serial_one_done_event && !wr_acc |=> $stable(serial_one_done_request);
    endproperty
    a_ser_stable: assert property (p_ser_stable) else $error("serial request moved");
    property p_ext_hold;
        !wr_acc |=> (ext_req_request & $past(ext_req_request)) == $past(ext_req_request);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("pin request cleared alone");
    property p_num_hold;
        !wr_acc |=> (numbered_pin_request & $past(numbered_pin_request))
            == $past(numbered_pin_request);
    endproperty
    a_num_hold: assert property (p_num_hold) else $error("numbered flag cleared alone");
    property p_ty_pulse; timer_y_edge |=> !timer_y_edge; endproperty
    a_ty_pulse: assert property (p_ty_pulse) else $error("timer y edge too long");
    property p_tmb_pulse; timer_b_edge |=> !timer_b_edge; endproperty
    a_tmb_pulse: assert property (p_tmb_pulse) else $error("timer b edge too long");
    property p_cv_pulse; converter_trigger_edge |=> !converter_trigger_edge; endproperty
    a_cv_pulse: assert property (p_cv_pulse) else $error("trigger edge too long");
endmodule // iesae_top_chk

bind iesae_top iesae_top_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .direct_transfer_event(direct_transfer_event),
    .converter_done_event(converter_done_event), .serial_one_done_event(serial_one_done_event),
    .cpu_int_mask(cpu_int_mask), .ext_req_request(ext_req_request),
    .numbered_pin_request(numbered_pin_request), .timer_b_one_request(timer_b_one_request),
    .timer_a_request(timer_a_request), .direct_transfer_request(direct_transfer_request),
    .converter_done_request(converter_done_request),
    .serial_one_done_request(serial_one_done_request), .irq_accept(irq_accept),
    .timer_y_edge(timer_y_edge), .timer_b_edge(timer_b_edge),
    .converter_trigger_edge(converter_trigger_edge));

//--- iesae_periph_model.sv
// iesae_periph_model: pins and event sources on the far side, plus edge counters.
// assumes: driven from the bench through its tasks, right after pclk edges.
`timescale 1ns/100ps
module iesae_periph_model (
    input wire logic pclk,
    input wire logic timer_y_edge,
    input wire logic timer_b_edge,
    input wire logic converter_trigger_edge,
    output logic [3:0] ext_request_pin,
    output logic [7:0] numbered_irq_pin,
    output logic [2:0] shared_pins,
    output logic [4:0] events
);
    int ty_cnt = 0;
    int tb_cnt = 0;
    int cv_cnt = 0;

    // pins idle high so the synchronisers see no edge at start
    initial begin
        ext_request_pin = 4'hF;
        numbered_irq_pin = 8'hFF;
        shared_pins = 3'h7;
        events = 5'h00;
    end

    // pins change only right after an edge, never near sampling
    task automatic drive_pins(input logic [3:0] e, input logic [7:0] n, input logic [2:0] s);
        @(posedge pclk);
        ext_request_pin <= e;
        numbered_irq_pin <= n;
        shared_pins <= s;
    endtask

    // events are single-cycle pulses, as the peripherals give them
    task automatic fire(input logic [4:0] ev);
        @(posedge pclk);
        events <= ev;
        @(posedge pclk);
        events <= 5'h00;
    endtask

    // the timers and converter consume one pulse per detected edge
    always @(posedge pclk) begin
        ty_cnt <= ty_cnt + (timer_y_edge === 1'b1);
        tb_cnt <= tb_cnt + (timer_b_edge === 1'b1);
        cv_cnt <= cv_cnt + (converter_trigger_edge === 1'b1);
    end
endmodule // iesae_periph_model

//--- iesae_tb_top.sv
// iesae_tb_top: register, event and edge tests through an APB master.
// assumes: design files and package compiled first; checker bound separately.
`timescale 1ns/100ps
module iesae_tb_top;
    import iesae_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic cpu_int_mask = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, irq_accept, ty_e, tb_e, cv_e;
    logic [3:0] ext_pin, ext_req;
    logic [7:0] num_pin, num_req;
    logic [2:0] shr;
    logic [4:0] ev, req5;
    logic [31:0] rv;
    logic er;
    int failures = 0;
    int n_tests = 0;
    logic [5:0] idx [4] = '{IDX_EXT_EDGE, IDX_PIN_EDGE, IDX_TMR_EN, IDX_PER_EN};
    logic [7:0] rstv [4] = '{8'h70, 8'h00, 8'h10, 8'h00};
    logic [7:0] onev [4] = '{8'h7F, 8'hFF, 8'hDF, 8'hD0};

    always #2.5 pclk = ~pclk;

    iesae_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_request_pin(ext_pin), .numbered_irq_pin(num_pin),
        .timer_y_event_in(shr[2]), .timer_b_event_in(shr[1]), .converter_trigger_in(shr[0]),
        .timer_y_edge(ty_e), .timer_b_edge(tb_e), .converter_trigger_edge(cv_e),
        .timer_b_one_overflow(ev[4]), .timer_a_overflow(ev[3]), .direct_transfer_event(ev[2]),
        .converter_done_event(ev[1]), .serial_one_done_event(ev[0]), .cpu_int_mask(cpu_int_mask),
        .ext_req_request(ext_req), .numbered_pin_request(num_req),
        .timer_b_one_request(req5[4]), .timer_a_request(req5[3]),
        .direct_transfer_request(req5[2]), .converter_done_request(req5[1]),
        .serial_one_done_request(req5[0]), .irq_accept(irq_accept));

    iesae_periph_model model_u (.pclk(pclk), .timer_y_edge(ty_e), .timer_b_edge(tb_e),
        .converter_trigger_edge(cv_e), .ext_request_pin(ext_pin), .numbered_irq_pin(num_pin),
        .shared_pins(shr), .events(ev));

    // --------------------------------------------------------
    // bus and compare tasks
    // --------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // the request stays up until pready is sampled high; no latency assumed
    task automatic apb(input logic w, input logic [5:0] ix, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, ADDR_ALIGN};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [5:0] ix, input logic [7:0] exp);
        apb(1'b0, ix, 8'h00);
        chk("register", {24'h0, exp}, rv);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // tests
    // --------------------------------------------------------
    // generous bound: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, writable bits and fixed reserved bits
        for (int i = 0; i < 4; i++) begin
            rdc(idx[i], rstv[i]);
            apb(1'b1, idx[i], 8'hFF);
            rdc(idx[i], onev[i]);
            apb(1'b1, idx[i], 8'h00);
            rdc(idx[i], rstv[i]);
        end
        apb(1'b0, 6'h0F, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, er});
        // events with enables off set flags but raise no request
        model_u.fire(5'h1F);
        @(posedge pclk);
        chk("blocked requests", 32'h0, {27'h0, req5});
        apb(1'b1, IDX_TMR_EN, 8'hCF);
        apb(1'b1, IDX_PER_EN, 8'hD0);
        @(posedge pclk);
        chk("enabled requests", 32'h1F, {27'h0, req5});
        chk("masked accept", 32'h0, {31'h0, irq_accept});
        cpu_int_mask <= 1'b0;
        @(posedge pclk);
        chk("open accept", 32'h1, {31'h0, irq_accept});
        apb(1'b1, IDX_FLAG2, 8'hFF);
        rdc(IDX_FLAG2, 8'hD0);
        apb(1'b1, IDX_PER_EN, 8'h50);
        @(posedge pclk);
        chk("direct gated", 32'h3, {29'h0, req5[2:0]});
        apb(1'b1, IDX_FLAG2, 8'h00);
        rdc(IDX_FLAG2, 8'h00);
        apb(1'b1, IDX_FLAG1, 8'h00);
        rdc(IDX_FLAG1, 8'h10);
        // mixed edge choices, then falling and rising pin transitions
        apb(1'b1, IDX_EXT_EDGE, 8'h05);
        apb(1'b1, IDX_PIN_EDGE, 8'hA5);
        model_u.drive_pins(4'h0, 8'h00, 3'h0);
        repeat (8) @(posedge pclk);
        rdc(IDX_FLAG1, 8'h1A);
        chk("pin requests", 32'hA, {28'h0, ext_req});
        chk("numbered falls", 32'h5A, {24'h0, num_req});
        chk("edges on fall", 32'h010, {model_u.ty_cnt[3:0], model_u.tb_cnt[3:0],
            model_u.cv_cnt[3:0]});
        model_u.drive_pins(4'hF, 8'hFF, 3'h7);
        repeat (8) @(posedge pclk);
        rdc(IDX_FLAG1, 8'h1F);
        chk("numbered rises", 32'hFF, {24'h0, num_req});
        chk("edges on rise", 32'h111, {model_u.ty_cnt[3:0], model_u.tb_cnt[3:0],
            model_u.cv_cnt[3:0]});
        apb(1'b1, IDX_FLAG3, 8'h00);
        rdc(IDX_FLAG3, 8'h00);
        wrap_up();
    end
endmodule // iesae_tb_top
